// >>> verilog/dram_refresh_ctrl.sv
/*
 * Controller end: APB registers, mode-register programming sequence and
 * periodic refresh issue on the command pins.
 * Assumes APB runs on ref_clk; the temperature band is written by software.
 */
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module dram_refresh_ctrl (
   input  wire logic        ref_clk,  // Command clock.
   input  wire logic        nrst,     // Asynchronous reset, active low.
   dram_ref_if.ctrl         pins,     // Command pins to the device.
   input  wire logic        psel,     // APB select.
   input  wire logic        penable,  // APB enable.
   input  wire logic        pwrite,   // APB write.
   input  wire logic [7:0]  paddr,    // APB byte address.
   input  wire logic [31:0] pwdata,   // APB write data.
   output logic [31:0]      prdata,   // APB read data.
   output logic             pready,   // APB ready.
   output logic             pslverr   // APB error on unmapped address.
);
   import dram_ref_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE    = 3'h0,
      S_RATE    = 3'h1,
      S_TCR     = 3'h2,
      S_REF     = 3'h3,
      S_OFF     = 3'h4,
      S_GAP1    = 3'h5,
      S_GAP2    = 3'h6
   } state_type;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave.

   logic [31:0] ctrl_q;
   logic [31:0] temp_q;
   logic [31:0] prdata_q;
   logic        cfgPend_q;
   logic        busy;
   logic        tcrProg_q;
   logic [15:0] refCount_q;
   logic        mapped;
   logic        wrAccess;
   logic        cfgDone;
   state_type   state_q;

   assign mapped   = paddr == REG_CTRL || paddr == REG_TEMP || paddr == REG_STATUS;
   assign wrAccess = psel && penable && pwrite && mapped;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign prdata   = prdata_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RESET;
         temp_q <= TEMP_RESET;
      end else if (wrAccess && paddr == REG_CTRL) begin
         ctrl_q <= pwdata;
      end else if (wrAccess && paddr == REG_TEMP) begin
         temp_q <= {29'h0, pwdata[2:0]};
      end
   end

   // Read data is captured in setup so it is stable through the access phase.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_q <= 32'h0;
      end else if (psel && !penable) begin
         unique case (paddr)
            REG_CTRL:   prdata_q <= ctrl_q;
            REG_TEMP:   prdata_q <= temp_q;
            REG_STATUS: prdata_q <= {refCount_q, 14'h0, tcrProg_q, busy};
            default:    prdata_q <= 32'h0;
         endcase
      end
   end

   // A control write asks for reprogramming; a new write wins over completion.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cfgPend_q <= 1'b1;
      end else if (wrAccess && paddr == REG_CTRL) begin
         cfgPend_q <= 1'b1;
      end else if (cfgDone) begin
         cfgPend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Refresh interval selection.

   rate_mode_type rateReq;
   rate_mode_type rateProg_q;
   logic          extProg_q;
   logic          otfHi;
   logic [9:0]    baseCyc;
   logic [9:0]    interval;
   logic [9:0]    timer_q;

   assign rateReq = rate_mode_type'(ctrl_q[CTRL_RATE_LSB+2:CTRL_RATE_LSB]);
   // The fast on-the-fly refresh is only sent once an on-the-fly mode is programmed.
   assign otfHi   = ctrl_q[CTRL_OTF_HI] && (rateProg_q == RATE_OTF_1X2 || rateProg_q == RATE_OTF_1X4);

   always_comb begin
      baseCyc = REFI_BASE_CYC;
      unique case (temp_band_type'(temp_q[2:0]))
         TEMP_COLD, TEMP_LE85: baseCyc = (tcrProg_q && extProg_q) ? REFI_EXT_CYC : REFI_BASE_CYC;
         TEMP_LE95:            baseCyc = REFI_EXT_CYC;
         TEMP_LE105:           baseCyc = REFI_HOT_CYC;
         default:              baseCyc = REFI_VHOT_CYC;
      endcase
      interval = baseCyc;
      if (rateProg_q == RATE_FIX_2X || (rateProg_q == RATE_OTF_1X2 && otfHi)) begin
         interval = baseCyc >> 1;
      end else if (rateProg_q == RATE_FIX_4X || (rateProg_q == RATE_OTF_1X4 && otfHi)) begin
         interval = baseCyc >> 2;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         timer_q <= 10'h0;
      end else if (state_q == S_REF) begin
         // This refresh cycle and the idle cycle that decides the next one each add one, so the load is two short.
         timer_q <= 10'(interval - 10'h2);
      end else if (cfgDone) begin
         // A new setting gets its first refresh at once, never an old, longer wait.
         timer_q <= 10'h0;
      end else if (timer_q != 10'h0) begin
         timer_q <= 10'(timer_q - 10'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer: every command is followed by one deselect cycle.

   logic        tcrWant;
   logic        cmdValid;
   logic        cmdIsMrs;
   logic [2:0]  cmdMr;
   logic [ADDR_W-1:0] cmdData;

   // Skipping is only requested alongside fixed 1x; otherwise it is left off.
   assign tcrWant = ctrl_q[CTRL_TCR_EN] && rateProg_q == RATE_FIX_1X;
   assign busy    = state_q != S_IDLE;
   assign cfgDone = state_q == S_TCR;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_IDLE;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (cfgPend_q) begin
                  state_q <= S_OFF;
               end else if (ctrl_q[CTRL_REF_EN] && timer_q == 10'h0) begin
                  state_q <= S_REF;
               end
            end
            S_OFF:   state_q <= S_GAP1;
            S_GAP1:  state_q <= S_RATE;
            S_RATE:  state_q <= S_GAP2;
            S_GAP2:  state_q <= S_TCR;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rateProg_q <= RATE_FIX_1X;
         tcrProg_q  <= 1'b0;
         extProg_q  <= 1'b0;
         refCount_q <= 16'h0;
      end else begin
         if (state_q == S_RATE) begin
            rateProg_q <= rateReq;
         end
         if (state_q == S_TCR) begin
            tcrProg_q <= tcrWant;
            extProg_q <= ctrl_q[CTRL_EXT];
         end
         if (state_q == S_REF) begin
            refCount_q <= 16'(refCount_q + 16'h1);
         end
      end
   end

   // Order: skipping off first, then the rate field, then skipping back on when tcrWant is set.
   always_comb begin
      cmdValid = 1'b1;
      cmdIsMrs = 1'b1;
      cmdMr    = MR_TCR_NUM;
      cmdData  = '0;
      unique case (state_q)
         S_IDLE, S_GAP1, S_GAP2: cmdValid = 1'b0;
         S_OFF: cmdData = '0;
         S_RATE: begin
            cmdMr                        = MR_RATE_NUM;
            cmdData[RATE_LSB+2:RATE_LSB] = rateReq;
         end
         S_TCR: begin
            cmdData[TCR_EN_BIT]    = tcrWant;
            cmdData[TCR_RANGE_BIT] = ctrl_q[CTRL_EXT];
         end
         default: cmdIsMrs = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pins.csN  <= 1'b1;
         pins.actN <= 1'b1;
         pins.rasN <= 1'b1;
         pins.casN <= 1'b1;
         pins.weN  <= 1'b1;
         pins.bg0  <= 1'b0;
         pins.bg1  <= 1'b0;
         pins.ba   <= 2'h0;
         pins.addr <= '0;
      end else begin
         pins.actN <= 1'b1;
         pins.bg1  <= 1'b0;
         if (cmdValid) begin
            pins.csN  <= 1'b0;
            pins.rasN <= 1'b0;
            pins.casN <= 1'b0;
            pins.weN  <= !cmdIsMrs;
            pins.bg0  <= cmdIsMrs ? cmdMr[2] : otfHi;
            pins.ba   <= cmdIsMrs ? cmdMr[1:0] : 2'h0;
            pins.addr <= cmdData;
         end else begin
            pins.csN  <= 1'b1;
            pins.rasN <= 1'b1;
            pins.casN <= 1'b1;
            pins.weN  <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// >>> common/dram_ref_pkg.sv
/*
 * Shared constants for the refresh-mode logic of the memory device and for
 * the controller that drives its command pins.
 * Assumes both ends run on the one 50 MHz command clock.
 */
package dram_ref_pkg;

   // Clock and refresh timing.
   localparam int CLK_PERIOD_NS = 20;
   localparam int REFI_BASE_NS  = 7800;
   localparam int REFI_EXT_NS   = 3900;
   localparam int REFI_HOT_NS   = 1950;
   localparam int REFI_VHOT_NS  = 975;
   // The two shortest intervals round down to whole cycles.
   localparam logic [9:0] REFI_BASE_CYC = 10'(REFI_BASE_NS / CLK_PERIOD_NS);
   localparam logic [9:0] REFI_EXT_CYC  = 10'(REFI_EXT_NS / CLK_PERIOD_NS);
   localparam logic [9:0] REFI_HOT_CYC  = 10'(REFI_HOT_NS / CLK_PERIOD_NS);
   localparam logic [9:0] REFI_VHOT_CYC = 10'(REFI_VHOT_NS / CLK_PERIOD_NS);

   // Mode register numbers and field positions.
   localparam logic [2:0] MR_RATE_NUM   = 3'h3;
   localparam logic [2:0] MR_TCR_NUM    = 3'h4;
   localparam int         RATE_LSB      = 6;
   localparam int         TCR_EN_BIT    = 3;
   localparam int         TCR_RANGE_BIT = 2;
   localparam int         ADDR_W        = 14;

   // Refresh skip ratios under temperature-controlled refresh.
   localparam logic [2:0] SKIP_NORM_COLD = 3'h2;
   localparam logic [2:0] SKIP_EXT_COLD  = 3'h4;
   localparam logic [2:0] SKIP_EXT_WARM  = 3'h2;
   localparam logic [2:0] SKIP_NONE      = 3'h1;

   typedef enum logic [2:0] {
      RATE_FIX_1X  = 3'h0,
      RATE_FIX_2X  = 3'h1,
      RATE_FIX_4X  = 3'h2,
      RATE_RSV_3   = 3'h3,
      RATE_RSV_4   = 3'h4,
      RATE_OTF_1X2 = 3'h5,
      RATE_OTF_1X4 = 3'h6,
      RATE_RSV_7   = 3'h7
   } rate_mode_type;

   // Case-temperature band: cold, up to 85, up to 95, up to 105, above 105.
   typedef enum logic [2:0] {
      TEMP_COLD = 3'h0,
      TEMP_LE85 = 3'h1,
      TEMP_LE95 = 3'h2,
      TEMP_LE105 = 3'h3,
      TEMP_GT105 = 3'h4
   } temp_band_type;

   typedef enum logic [1:0] {
      REF_1X = 2'h0,
      REF_2X = 2'h1,
      REF_4X = 2'h2
   } ref_kind_type;

   // Controller register map (byte addresses) and reset values.
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_TEMP   = 8'h04;
   localparam logic [7:0]  REG_STATUS = 8'h08;
   localparam int          CTRL_REF_EN  = 0;
   localparam int          CTRL_TCR_EN  = 1;
   localparam int          CTRL_EXT     = 2;
   localparam int          CTRL_OTF_HI  = 3;
   localparam int          CTRL_RATE_LSB = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] TEMP_RESET = 32'h0000_0001;

endpackage

// >>> common/dram_ref_if.sv
/*
 * Command pins between the memory controller and the memory device.
 * Assumes both ends sample the pins on the same ref_clk edge.
 */
`timescale 1ns/1ps
`default_nettype none

interface dram_ref_if;
   import dram_ref_pkg::*;
   logic              csN;
   logic              actN;
   logic              rasN;
   logic              casN;
   logic              weN;
   logic              bg0;
   logic              bg1;
   logic [1:0]        ba;
   logic [ADDR_W-1:0] addr;

   modport ctrl (output csN, actN, rasN, casN, weN, bg0, bg1, ba, addr);
   modport dev  (input  csN, actN, rasN, casN, weN, bg0, bg1, ba, addr);
endinterface

`default_nettype wire

// >>> verilog/dram_refresh_rate_mode.sv
/*
 * Device end: mode-register decode, refresh command decode, fine-granularity
 * rate selection and temperature-controlled refresh skipping.
 * Assumes the command pins come from logic on ref_clk; the temperature band
 * comes from an on-die sensor outside this clock and is synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Controller refreshes per interval when skipping off
// - Mode register 4 bit 3 enables skipping
// - Mode register 4 bit 2 selects range
// - Accept every refresh, skip by gear ratio
// - Controller programs matching temperature range
// - Normal range: 7.8us, skip when cool
// - Extended range: faster external, skip when cool
// - Extended range never slower than 3.9us
// - Decode refresh-rate field, three codes reserved
// - Fixed uses one set, on-the-fly two
// - Program on-the-fly mode before using it
// - Bank-group bit 0 picks rate per refresh
// - Refresh recognised from the five control pins
// - Skipping only with fixed 1x rate
module dram_refresh_rate_mode #(
   parameter logic [2:0] SKIP_NORM_COLD_P = dram_ref_pkg::SKIP_NORM_COLD,
   parameter logic [2:0] SKIP_EXT_COLD_P  = dram_ref_pkg::SKIP_EXT_COLD,
   parameter logic [2:0] SKIP_EXT_WARM_P  = dram_ref_pkg::SKIP_EXT_WARM
) (
   input  wire logic                        ref_clk,       // Command clock.
   input  wire logic                        nrst,          // Asynchronous reset, active low.
   dram_ref_if.dev                          pins,          // Command pins from the controller.
   input  wire logic [2:0]                  tempBand,      // Case-temperature band from the sensor.
   output logic                             extRefresh,    // Refresh command accepted.
   output logic                             intRefresh,    // Internal refresh performed.
   output dram_ref_pkg::ref_kind_type       intKind,       // Kind of the last refresh.
   output dram_ref_pkg::ref_kind_type       timingSet,     // Selected cycle-time and interval set.
   output logic                             otfMode,       // On-the-fly rate selection active.
   output logic                             reservedRate,  // Rate field holds a reserved code.
   output logic                             tcrActive,     // Temperature-controlled refresh on.
   output logic                             tcrExtRange,   // Extended temperature range selected.
   output dram_ref_pkg::rate_mode_type      rateMode       // Programmed refresh-rate field.
);
   import dram_ref_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode.

   logic       cmdRef;
   logic       cmdMrs;
   logic [2:0] mrNum;

   assign cmdRef = !pins.csN && pins.actN && !pins.rasN && !pins.casN && pins.weN;
   assign cmdMrs = !pins.csN && pins.actN && !pins.rasN && !pins.casN && !pins.weN;
   assign mrNum  = {pins.bg0, pins.ba};

   ////////////////////////////////////////////////////////////////////////////
   // Temperature band synchroniser.

   logic [2:0] tempMeta_q;
   logic [2:0] tempSync_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tempMeta_q <= 3'h0;
         tempSync_q <= 3'h0;
      end else begin
         tempMeta_q <= tempBand;
         tempSync_q <= tempMeta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode registers.

   rate_mode_type rate_q;
   logic          tcrOn_q;
   logic          extRange_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rate_q <= RATE_FIX_1X;
      end else if (cmdMrs && mrNum == MR_RATE_NUM) begin
         rate_q <= rate_mode_type'(pins.addr[RATE_LSB+2:RATE_LSB]);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tcrOn_q    <= 1'b0;
         extRange_q <= 1'b0;
      end else if (cmdMrs && mrNum == MR_TCR_NUM) begin
         tcrOn_q    <= pins.addr[TCR_EN_BIT];
         extRange_q <= pins.addr[TCR_RANGE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Rate selection per refresh.

   ref_kind_type kind;
   logic         isOtf;
   logic         isReserved;

   always_comb begin
      kind       = REF_1X;
      isOtf      = 1'b0;
      isReserved = 1'b0;
      unique case (rate_q)
         RATE_FIX_1X: kind = REF_1X;
         RATE_FIX_2X: kind = REF_2X;
         RATE_FIX_4X: kind = REF_4X;
         RATE_OTF_1X2: begin
            isOtf = 1'b1;
            kind  = pins.bg0 ? REF_2X : REF_1X;
         end
         RATE_OTF_1X4: begin
            isOtf = 1'b1;
            kind  = pins.bg0 ? REF_4X : REF_1X;
         end
         RATE_RSV_3, RATE_RSV_4, RATE_RSV_7: begin
            isReserved = 1'b1;
            kind       = REF_1X;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Skip ratio from the case-temperature estimate.

   logic [2:0] ratio;

   always_comb begin
      ratio = SKIP_NONE;
      // Skipping only applies to plain 1x refreshes; other modes refresh every time.
      if (tcrOn_q && rate_q == RATE_FIX_1X) begin
         if (!extRange_q) begin
            // Normal range: the controller supplies 7.8 us; stretch only when cold.
            if (tempSync_q == TEMP_COLD) begin
               ratio = SKIP_NORM_COLD_P;
            end
         end else begin
            // Extended range: 3.9 us external, internal period kept at 7.8 us or more up to 85 C.
            if (tempSync_q == TEMP_COLD) begin
               ratio = SKIP_EXT_COLD_P;
            end else if (tempSync_q == TEMP_LE85) begin
               ratio = SKIP_EXT_WARM_P;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Refresh counter and internal refresh issue.

   logic [2:0] skipCnt_q;
   logic [2:0] skipCnt_d;
   logic       doRefresh;

   always_comb begin
      doRefresh = 1'b0;
      skipCnt_d = skipCnt_q;
      if (cmdRef) begin
         // Every external refresh is registered; only every ratio-th one is executed.
         if (3'(skipCnt_q + 3'h1) >= ratio) begin
            doRefresh = 1'b1;
            skipCnt_d = 3'h0;
         end else begin
            skipCnt_d = 3'(skipCnt_q + 3'h1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         skipCnt_q <= 3'h0;
      end else if (cmdMrs && mrNum == MR_TCR_NUM) begin
         // A new skipping setting restarts the gear from the first refresh.
         skipCnt_q <= 3'h0;
      end else begin
         skipCnt_q <= skipCnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   logic         extRefresh_q;
   logic         intRefresh_q;
   ref_kind_type intKind_q;
   ref_kind_type timingSet_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         extRefresh_q <= 1'b0;
         intRefresh_q <= 1'b0;
      end else begin
         extRefresh_q <= cmdRef;
         intRefresh_q <= doRefresh;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         intKind_q   <= REF_1X;
         timingSet_q <= REF_1X;
      end else if (cmdMrs && mrNum == MR_RATE_NUM) begin
         // A fixed mode selects its set at once; on-the-fly falls back to 1x.
         unique case (pins.addr[RATE_LSB+2:RATE_LSB])
            RATE_FIX_2X: timingSet_q <= REF_2X;
            RATE_FIX_4X: timingSet_q <= REF_4X;
            default:     timingSet_q <= REF_1X;
         endcase
      end else if (cmdRef) begin
         intKind_q   <= kind;
         timingSet_q <= kind;
      end
   end

   assign extRefresh   = extRefresh_q;
   assign intRefresh   = intRefresh_q;
   assign intKind      = intKind_q;
   assign timingSet    = timingSet_q;
   assign otfMode      = isOtf;
   assign reservedRate = isReserved;
   assign tcrActive    = tcrOn_q;
   assign tcrExtRange  = extRange_q;
   assign rateMode     = rate_q;

endmodule

`default_nettype wire

// >>> tb/dram_refresh_properties.sv
/* Checks on the command pins between controller and device.
   Assumes pins change only on ref_clk and nrst is active low. */
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_properties (
   input wire logic        ref_clk, // Clock.
   input wire logic        nrst,    // Reset.
   input wire logic        csN,     // Select.
   input wire logic        actN,    // Activate.
   input wire logic        rasN,    // Row strobe.
   input wire logic        casN,    // Column strobe.
   input wire logic        weN,     // Write enable.
   input wire logic        bg0,     // Bank group 0.
   input wire logic [1:0]  ba,      // Bank.
   input wire logic [13:0] addr     // Address.
);
   import dram_ref_pkg::*;
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic       refC;
   logic       mr3C;
   logic       mr4C;
   logic [2:0] rate_q;
   assign refC = !csN && !rasN && !casN && weN;
   assign mr3C = !csN && !weN && {bg0, ba} == 3'h3;
   assign mr4C = !csN && !weN && {bg0, ba} == 3'h4;
   // Tracks the rate field last sent to the device.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) rate_q <= 3'h0;
      else if (mr3C) rate_q <= addr[8:6];
   end
   logic       extOn_q;
   logic [9:0] gap_q;
   // Cycles since the last refresh while extended-range skipping is programmed.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         extOn_q <= 1'b0;
         gap_q   <= 10'h0;
      end else begin
         if (mr4C) extOn_q <= addr[3] && addr[2];
         gap_q <= (refC || !extOn_q) ? 10'h0 : 10'(gap_q + 10'h1);
      end
   end
   sequence s_rate_set; mr3C; endsequence
   sequence s_mr4_after; ##2 mr4C; endsequence
   ////////////////////////////////////////////////////////////
   a_cmd_desel: assert property (!csN |=> csN)
      else $error("command not followed by deselect");
   a_cmd_encode: assert property (!csN |-> actN && !rasN && !casN)
      else $error("bad command encoding");
   a_mr3_prep: assert property (s_rate_set |-> $past(mr4C, 2) && !$past(addr[3], 2))
      else $error("rate change without skipping off");
   a_mr4_follow: assert property (s_rate_set |-> s_mr4_after)
      else $error("range register not rewritten");
   a_tcr_fixed: assert property (mr4C && addr[3] |-> rate_q == 3'h0)
      else $error("skipping enabled outside fixed 1x");
   a_otf_prog: assert property (refC && bg0 |-> rate_q inside {3'h5, 3'h6})
      else $error("fast refresh without on-the-fly mode");
   a_ref_space: assert property (refC |=> !refC [*8])
      else $error("refreshes too close");
   a_rst_desel: assert property ($rose(nrst) |-> csN && weN)
      else $error("pins not idle at reset release");
   a_ext_spacing: assert property (gap_q < REFI_EXT_CYC)
      else $error("extended-range refreshes too far apart");
endmodule
`default_nettype wire

// >>> tb/tb_dram_refresh_rate_mode_logic.sv
/* Testbench: controller and device joined by the command interface.
   Assumes 50 MHz ref_clk and the register map of the shared package. */
`timescale 1ns/1ps
`default_nettype none
module tb_dram_refresh_rate_mode_logic;
   import dram_ref_pkg::*;
   logic          ref_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [2:0]    tempBand;
   logic          extRefresh, intRefresh, otfMode, reservedRate, tcrActive, tcrExtRange;
   ref_kind_type  intKind, timingSet;
   rate_mode_type rateMode;
   int            n_errors = 0, compares = 0, cyc = 0, ni;
   logic [31:0]   tCtl [4] = '{32'h7, 32'h3, 32'h7, 32'h13};
   logic [2:0]    tBnd [4] = '{3'h0, 3'h0, 3'h2, 3'h1};
   int            tN [4] = '{8, 4, 4, 4};
   int            tI [4] = '{2, 2, 4, 4};
   logic [31:0]   oCtl [4] = '{32'h59, 32'h69, 32'h51, 32'h21};
   ref_kind_type  oK [4] = '{REF_2X, REF_4X, REF_1X, REF_4X};
   dram_ref_if pins ();
   dram_refresh_ctrl u_dram_refresh_ctrl (.ref_clk(ref_clk), .nrst(nrst), .pins(pins), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   dram_refresh_rate_mode u_dram_refresh_rate_mode (.ref_clk(ref_clk), .nrst(nrst), .pins(pins),
      .tempBand(tempBand), .extRefresh(extRefresh), .intRefresh(intRefresh), .intKind(intKind),
      .timingSet(timingSet), .otfMode(otfMode), .reservedRate(reservedRate),
      .tcrActive(tcrActive), .tcrExtRange(tcrExtRange), .rateMode(rateMode));
   dram_refresh_properties u_dram_refresh_properties (.ref_clk(ref_clk), .nrst(nrst),
      .csN(pins.csN), .actN(pins.actN), .rasN(pins.rasN), .casN(pins.casN), .weN(pins.weN),
      .bg0(pins.bg0), .ba(pins.ba), .addr(pins.addr));
   ////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("[ERR] %0t timeout", $time);
         stop_test();
      end
   end
   task stop_test();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // One APB transfer; holds the request until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk(32'(er), 32'(e));
   endtask
   task cfg(input logic [2:0] t, input logic [31:0] c);
      apb(1'b1, REG_TEMP, 32'(t));
      tempBand <= t;
      apb(1'b1, REG_CTRL, c);
   endtask
   // Counts internal refreshes over n accepted refresh commands.
   task runRef(input int n);
      int k;
      k = 0;
      ni = 0;
      while (k < n) begin
         @(posedge ref_clk);
         #1;
         if (extRefresh === 1'b1) k++;
         if (intRefresh === 1'b1) ni++;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tempBand = 3'h1;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      rdc(REG_CTRL, CTRL_RESET, 1'b0);
      rdc(REG_TEMP, TEMP_RESET, 1'b0);
      apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      rdc(8'h0C, 32'h0, 1'b1);
      $display("test regs done");
      for (int i = 0; i < 8; i++) begin
         cfg(3'h1, 32'(i << CTRL_RATE_LSB));
         repeat (12) @(posedge ref_clk);
         #1;
         chk(32'(rateMode), 32'(i));
         chk(32'(otfMode), 32'(i == 5 || i == 6));
         chk(32'(reservedRate), 32'(i == 3 || i == 4 || i == 7));
      end
      $display("test rate field done");
      for (int j = 0; j < 4; j++) begin
         cfg(tBnd[j], tCtl[j]);
         runRef(tN[j]);
         chk(32'(ni), 32'(tI[j]));
         chk(32'(tcrActive), 32'(j < 3));
         chk(32'(tcrExtRange), 32'(tCtl[j][2]));
         rdc(REG_CTRL, tCtl[j], 1'b0);
      end
      $display("test skipping done");
      for (int j = 0; j < 4; j++) begin
         cfg(3'h1, oCtl[j]);
         runRef(1);
         chk(32'(intKind), 32'(oK[j]));
         chk(32'(timingSet), 32'(oK[j]));
      end
      $display("test on-the-fly done");
      stop_test();
   end
endmodule
`default_nettype wire
